// File: bench/xreg3_ctrl_assertions.sv
// Concurrent checks on the ports of the regulator control block
`timescale 1ns/1ns
`include "xreg3_map.svh"
module xreg3_ctrl_assertions
   import xreg3_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic soft_reset_in,
   input wire logic [`XREG3_MODE_W-1:0] chip_mode_in,
   input wire logic oc_clear_in,
   input wire logic battery_low_in,
   input wire xreg3_ctrl_t ctrl_out,
   input wire xreg3_stat_t stat_out,
   input wire logic spi_error_out,
   input wire logic config_locked_out,
   input wire logic share_mode_out,
   input wire logic regulator_on_out,
   input wire logic select_1v8_out,
   input wire logic current_limit_out,
   input wire logic low_power_stage_out,
   input wire logic high_power_stage_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   wire logic alone = config_locked_out && !share_mode_out;
   wire logic oc = stat_out.aux_overcurrent_flag;
   // Three samples cover the two-stage input synchroniser
   sequence s_low; battery_low_in [*3]; endsequence
   property p_lock;
      config_locked_out |=> config_locked_out && $stable(share_mode_out);
   endproperty
   a_lock: assert property (p_lock) else $error("lock moved");
   property p_quiet; alone && !spi_error_out |=> !spi_error_out; endproperty
   a_quiet: assert property (p_quiet) else $error("spi error");
   property p_vsel; alone |-> select_1v8_out == ctrl_out[2]; endproperty
   a_vsel: assert property (p_vsel) else $error("voltage");
   property p_off;
      chip_mode_in inside {`XREG3_MODE_INIT, `XREG3_MODE_FAILSAFE}
         |-> !regulator_on_out;
   endproperty
   a_off: assert property (p_off) else $error("on in init");
   property p_sleep;
      share_mode_out && chip_mode_in == `XREG3_MODE_SLEEP
         |-> !regulator_on_out;
   endproperty
   a_sleep: assert property (p_sleep) else $error("on in sleep");
   property p_flags; share_mode_out |-> stat_out == 2'h0; endproperty
   a_flags: assert property (p_flags) else $error("flag");
   property p_sticky; oc && !oc_clear_in && !soft_reset_in |=> oc; endproperty
   a_sticky: assert property (p_sticky) else $error("oc lost");
   property p_batt;
      s_low ##0 !ctrl_out.keep_on_at_supply_low |-> !regulator_on_out;
   endproperty
   a_batt: assert property (p_batt) else $error("on at low");
   property p_limit; current_limit_out |-> alone; endproperty
   a_limit: assert property (p_limit) else $error("limit");
   property p_vshare; share_mode_out |-> !select_1v8_out; endproperty
   a_vshare: assert property (p_vshare) else $error("voltage");
   property p_stage;
      chip_mode_in == `XREG3_MODE_NORMAL
         |-> !low_power_stage_out && high_power_stage_out == regulator_on_out;
   endproperty
   a_stage: assert property (p_stage) else $error("stage");
endmodule
bind xreg3_ctrl xreg3_ctrl_assertions u_chk (.*);

// File: bench/xreg3_ctrl_tb_top.sv
// Self-checking bench for the regulator control block
`timescale 1ns/1ns
`include "xreg3_map.svh"
module xreg3_ctrl_tb_top
   import xreg3_pkg::*;
();
   logic clk_sys_in = 1'h0, rst_b_in = 1'h0, soft_reset_in = 1'h0;
   logic ctrl_write_in = 1'h0, oc_clear_in = 1'h0, battery_low_in = 1'h0;
   logic [`XREG3_MODE_W-1:0] chip_mode_in = 3'h0;
   logic [1:0] load = 2'h0;
   logic shrt = 1'h0;
   xreg3_ctrl_t ctrl_in = 5'h00, ctrl_out;
   xreg3_stat_t stat_out;
   logic spi_error_out, config_locked_out, share_mode_out, regulator_on_out;
   logic current_limit_out, select_1v8_out, low_power_stage_out;
   logic high_power_stage_out, shunt_limit_in, output_low_in;
   logic drive_above_high_in, drive_below_low_in;
   wire logic on = regulator_on_out;
   wire logic oc = stat_out.aux_overcurrent_flag;
   int num_errors = 0, comparisons = 0;
   always #50 clk_sys_in = ~clk_sys_in;
   xreg3_ctrl dut (.*);
   xreg3_pnp_model pnp (.regulator_on_in(on), .load_level_in(load),
      .output_short_in(shrt), .shunt_limit_out(shunt_limit_in),
      .output_low_out(output_low_in),
      .drive_above_high_out(drive_above_high_in),
      .drive_below_low_out(drive_below_low_in));
   task automatic chk(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic cyc(input int n); repeat (n) @(negedge clk_sys_in); endtask
   task automatic md(input logic [2:0] m); chip_mode_in = m; cyc(1); endtask
   // Strobe drops for a full cycle so back-to-back writes stay distinct
   task automatic wr(input xreg3_ctrl_t c);
      ctrl_in = c;
      ctrl_write_in = 1'h1;
      cyc(1);
      ctrl_write_in = 1'h0;
      cyc(1);
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
      cyc(1);
   endtask
   task automatic por();
      rst_b_in = 1'h0;
      cyc(16);
      rst_b_in = 1'h1;
      cyc(1);
   endtask
   task automatic results();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   //**************************************************
   // Main sequence
   //**************************************************
   initial begin
      por();
      md(`XREG3_MODE_NORMAL);
      wr(5'h14);
      chk("locked", 1'h1, config_locked_out);
      chk("sel_1v8", 1'h1, select_1v8_out);
      wr(5'h18);
      chk("share", 1'h0, share_mode_out);
      chk("spi_err", 1'h0, spi_error_out);
      chk("ctrl_share", 1'h0, ctrl_out.load_share_select);
      wr(5'h00);
      chk("on", 1'h0, on);
      wr(5'h10);
      md(`XREG3_MODE_STOP);
      chk("on", 1'h1, on);
      chk("low_pwr", 1'h1, low_power_stage_out);
      load = 2'h2;
      cyc(3);
      chk("high_pwr", 1'h1, high_power_stage_out);
      chk("oc", 1'h1, oc);
      chk("climit", 1'h1, current_limit_out);
      pulse(oc_clear_in);
      chk("oc", 1'h1, oc);
      load = 2'h0;
      cyc(3);
      chk("oc", 1'h1, oc);
      pulse(oc_clear_in);
      chk("oc", 1'h0, oc);
      md(`XREG3_MODE_NORMAL);
      chk("low_pwr", 1'h0, low_power_stage_out);
      chk("high_pwr", 1'h1, high_power_stage_out);
      pulse(soft_reset_in);
      chk("locked", 1'h1, config_locked_out);
      wr(5'h10);
      battery_low_in = 1'h1;
      cyc(3);
      chk("on", 1'h0, on);
      battery_low_in = 1'h0;
      cyc(3);
      chk("on", 1'h1, on);
      shrt = 1'h1;
      cyc(3);
      chk("uv", 1'h1, stat_out.aux_undervoltage_flag);
      shrt = 1'h0;
      por();
      wr(5'h08);
      chk("share", 1'h1, share_mode_out);
      wr(5'h00);
      chk("spi_err", 1'h1, spi_error_out);
      chk("share", 1'h1, share_mode_out);
      md(`XREG3_MODE_STOP);
      chk("on", 1'h0, on);
      wr(5'h0e);
      chk("on", 1'h1, on);
      chk("sel_1v8", 1'h0, select_1v8_out);
      md(`XREG3_MODE_SLEEP);
      chk("on", 1'h0, on);
      md(`XREG3_MODE_RESTART);
      load = 2'h2;
      cyc(3);
      chk("on", 1'h1, on);
      chk("oc", 1'h0, oc);
      md(`XREG3_MODE_FAILSAFE);
      chk("on", 1'h0, on);
      results();
   end
endmodule

// File: bench/xreg3_pnp_model.sv
// Model of the external pass transistor, shunt and load
`timescale 1ns/1ns
module xreg3_pnp_model (
   input wire logic regulator_on_in,
   input wire logic [1:0] load_level_in,
   input wire logic output_short_in,
   output logic shunt_limit_out,
   output logic output_low_out,
   output logic drive_above_high_out,
   output logic drive_below_low_out
);
   // Load 0 light, 1 heavy, 2 beyond the shunt limit; nothing flows when off
   assign shunt_limit_out = regulator_on_in && load_level_in == 2'h2;
   assign output_low_out = regulator_on_in && output_short_in;
   assign drive_above_high_out = regulator_on_in && load_level_in != 2'h0;
   assign drive_below_low_out = !regulator_on_in || load_level_in == 2'h0;
endmodule

// File: hw/xreg3_ctrl.sv
// Control logic of the third supply regulator with external pass device
`timescale 1ns/1ns
`include "xreg3_map.svh"
// Behaviour
// - Enable written in normal mode with share bit clear locks stand-alone.
// - First share bit write locks load sharing; enable bit then ignored.
// - Chosen configuration stays fixed while powered, also over soft reset.
// - Stand-alone lock ignores configuration changes without raising SPI error.
// - Load-sharing lock flags SPI error on any change, keeps configuration.
// - Stand-alone output still switched on and off by enable bit.
// - Stand-alone voltage select: zero 3.3V, one 1.8V; ignored when sharing.
// - Mode table: init and fail-safe off; sharing sleep off, restart on.
// - Sharing off in stop unless keep-in-stop bit set; share bit stays.
// - Battery low turns regulator off unless keep-on bit; recovers itself.
// - Stand-alone shunt limit sets overcurrent flag; clear only after it ends.
// - Stand-alone output undervoltage reported by undervoltage flag.
// - Sharing never raises undervoltage or overcurrent flags; off in fail-safe.
// - Stop uses low-power stage, adds high-power by drive current hysteresis.
module xreg3_ctrl
   import xreg3_pkg::*;
#(
   parameter int MODE_W = `XREG3_MODE_W,
   parameter int PIN_COUNT = 5
) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic soft_reset_in,
   input wire logic [`XREG3_MODE_W-1:0] chip_mode_in,
   input wire logic ctrl_write_in,
   input wire xreg3_ctrl_t ctrl_in,
   input wire logic oc_clear_in,
   input wire logic battery_low_in,
   input wire logic shunt_limit_in,
   input wire logic output_low_in,
   input wire logic drive_above_high_in,
   input wire logic drive_below_low_in,
   output xreg3_ctrl_t ctrl_out,
   output xreg3_stat_t stat_out,
   output logic spi_error_out,
   output logic config_locked_out,
   output logic share_mode_out,
   output logic regulator_on_out,
   output logic current_limit_out,
   output logic select_1v8_out,
   output logic low_power_stage_out,
   output logic high_power_stage_out
);
   // ****************************************
   // Elaboration checks
   // ****************************************
   // The mode decoder and the pin bundle below are written for these sizes
   initial begin
      if (MODE_W != `XREG3_MODE_W) begin
         $error("MODE_W must match the mode code width");
      end
      if (PIN_COUNT != 5) begin
         $error("PIN_COUNT must be five");
      end
   end

   // ****************************************
   // Decoding helpers
   // ****************************************
   // Mode compare used by several decoders
   function automatic logic mode_is(
      input logic [MODE_W-1:0] mode,
      input logic [MODE_W-1:0] code
   );
      return mode == code;
   endfunction

   // Sticky flag update: an event in the clear cycle is never lost
   function automatic logic sticky_next(
      input logic cur,
      input logic set,
      input logic clr
   );
      logic result;
      result = cur;
      if (set) begin
         result = 1'b1;
      end else if (clr) begin
         result = 1'b0;
      end
      return result;
   endfunction

   // ****************************************
   // Pin synchronisation
   // ****************************************
   // Pins are asynchronous levels, so two stages precede every reader
   logic [PIN_COUNT-1:0] pins_sync;
   logic batt_low_s;
   logic shunt_s;
   logic out_low_s;
   logic drv_hi_s;
   logic drv_lo_s;
   xreg3_sync #(.WIDTH(PIN_COUNT)) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .async_in({battery_low_in, shunt_limit_in, output_low_in,
         drive_above_high_in, drive_below_low_in}),
      .sync_out(pins_sync)
   );
   assign {batt_low_s, shunt_s, out_low_s, drv_hi_s, drv_lo_s} = pins_sync;

   // ****************************************
   // Configuration lock
   // ****************************************
   // Held only by power-on reset; soft reset clears software bits only
   xreg3_cfg_t cfg_reg;
   xreg3_cfg_t cfg_next;
   xreg3_ctrl_t ctrl_reg;
   xreg3_ctrl_t ctrl_next;
   logic spi_err_reg;
   logic oc_reg;
   logic uv_reg;
   logic hp_reg;
   logic in_normal;
   logic in_stop;
   logic share;
   logic alone;
   logic cfg_change;
   logic err_set;
   logic mode_on;
   logic supply_ok;
   logic spi_err_next;
   logic oc_set;
   logic oc_clr;
   logic oc_next;
   logic uv_next;
   logic locked;
   logic share_flip;
   logic enable_ask;
   logic want_share;
   logic want_alone;
   logic hold_alone;
   logic stop_share;

   // ****************************************
   // Configuration write decode
   // ****************************************
   assign in_normal = mode_is(chip_mode_in, `XREG3_MODE_NORMAL);
   assign in_stop = mode_is(chip_mode_in, `XREG3_MODE_STOP);
   assign share = cfg_reg == XREG3_CFG_SHARE;
   assign alone = cfg_reg == XREG3_CFG_ALONE;
   assign locked = cfg_reg != XREG3_CFG_NONE;
   // Enable set while sharing counts as an attempt to move to stand-alone
   assign share_flip = ctrl_in.load_share_select != ctrl_reg.load_share_select;
   assign enable_ask = ctrl_in.aux_reg_enable;
   assign cfg_change = ctrl_write_in && (share_flip || enable_ask);
   assign err_set = share && cfg_change;
   // Share bit wins over enable so a mixed first write picks sharing
   assign want_share = !locked && ctrl_write_in && ctrl_in.load_share_select;
   assign want_alone = !locked && ctrl_write_in &&
      ctrl_in.aux_reg_enable && in_normal;

   always_comb begin
      cfg_next = cfg_reg;
      if (want_share) begin
         cfg_next = XREG3_CFG_SHARE;
      end else if (want_alone) begin
         cfg_next = XREG3_CFG_ALONE;
      end
   end

   // ****************************************
   // Lock and control registers
   // ****************************************
   // Soft reset keeps the share bit so sharing resumes after it
   always_comb begin
      ctrl_next = ctrl_reg;
      if (soft_reset_in) begin
         ctrl_next = '0;
         ctrl_next.load_share_select = share;
      end else if (ctrl_write_in) begin
         ctrl_next = ctrl_in;
         // lock keeps share bit fixed once configured
         if (share) begin
            ctrl_next.load_share_select = 1'b1;
            ctrl_next.aux_reg_enable = 1'b0;
         end else if (alone || cfg_next == XREG3_CFG_ALONE) begin
            ctrl_next.load_share_select = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_reg <= XREG3_CFG_NONE;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ****************************************
   // SPI error flag
   // ****************************************
   // Set wins over a clear in the same cycle
   assign spi_err_next = sticky_next(spi_err_reg, err_set,
      oc_clear_in || soft_reset_in);
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         spi_err_reg <= 1'b0;
      end else begin
         spi_err_reg <= spi_err_next;
      end
   end

   // ****************************************
   // Regulator on/off by mode and supply
   // ****************************************
   assign supply_ok = !batt_low_s || ctrl_reg.keep_on_at_supply_low;
   // Stand-alone holds its normal-mode choice through low-power modes
   assign hold_alone = alone && ctrl_reg.aux_reg_enable;
   assign stop_share = share && ctrl_reg.share_keep_in_stop;

   always_comb begin
      mode_on = 1'b0;
      case (chip_mode_in)
         `XREG3_MODE_INIT: mode_on = 1'b0;
         `XREG3_MODE_FAILSAFE: mode_on = 1'b0;
         `XREG3_MODE_NORMAL: mode_on = share || ctrl_reg.aux_reg_enable;
         `XREG3_MODE_STOP: mode_on = stop_share || hold_alone;
         `XREG3_MODE_SLEEP: mode_on = hold_alone;
         `XREG3_MODE_RESTART: mode_on = share || ctrl_reg.aux_reg_enable;
         default: mode_on = 1'b0;
      endcase
   end

   // ****************************************
   // Flags and output stages
   // ****************************************
   // Set only while the output drives, so an idle shunt cannot latch it
   assign oc_set = alone && regulator_on_out && shunt_s;
   assign oc_clr = oc_clear_in && !shunt_s;
   assign oc_next = sticky_next(oc_reg, oc_set, oc_clr);
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oc_reg <= 1'b0;
      end else begin
         oc_reg <= oc_next;
      end
   end

   // Undervoltage flag follows the output level; masked when sharing
   assign uv_next = alone && regulator_on_out && out_low_s;
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         uv_reg <= 1'b0;
      end else begin
         uv_reg <= uv_next;
      end
   end

   // Hysteresis between the two drive current thresholds
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hp_reg <= 1'b0;
      end else if (!in_stop) begin
         hp_reg <= 1'b0;
      end else if (drv_hi_s) begin
         hp_reg <= 1'b1;
      end else if (drv_lo_s) begin
         hp_reg <= 1'b0;
      end
   end


   // ****************************************
   // Output stages
   // ****************************************
   // An unconfigured regulator stays off whatever the mode asks
   assign regulator_on_out = mode_on && supply_ok && locked;
   assign current_limit_out = alone && shunt_s;
   assign select_1v8_out = alone && ctrl_reg.output_voltage_select;
   // Stop runs lean; the big stage joins only under heavy drive
   assign low_power_stage_out = regulator_on_out && in_stop;
   assign high_power_stage_out = regulator_on_out && (!in_stop || hp_reg);

   // ****************************************
   // Status outputs
   // ****************************************
   assign ctrl_out = ctrl_reg;
   assign stat_out.aux_overcurrent_flag = oc_reg && !share;
   assign stat_out.aux_undervoltage_flag = uv_reg;
   assign spi_error_out = spi_err_reg;
   assign config_locked_out = locked;
   assign share_mode_out = share;
endmodule

// File: hw/xreg3_map.svh
// Constants for the third supply regulator control block
`ifndef XREG3_MAP_SVH
`define XREG3_MAP_SVH
`define XREG3_CFG_RST 2'h0
`define XREG3_MODE_W 3
`define XREG3_MODE_INIT 3'h0
`define XREG3_MODE_NORMAL 3'h1
`define XREG3_MODE_STOP 3'h2
`define XREG3_MODE_SLEEP 3'h3
`define XREG3_MODE_RESTART 3'h4
`define XREG3_MODE_FAILSAFE 3'h5
`endif

// File: hw/xreg3_pkg.sv
// Types for the third supply regulator control block
package xreg3_pkg;
   typedef enum logic [1:0] {
      XREG3_CFG_NONE,
      XREG3_CFG_ALONE,
      XREG3_CFG_SHARE
   } xreg3_cfg_t;
   typedef struct packed {
      logic aux_reg_enable;
      logic load_share_select;
      logic output_voltage_select;
      logic share_keep_in_stop;
      logic keep_on_at_supply_low;
   } xreg3_ctrl_t;
   typedef struct packed {
      logic aux_overcurrent_flag;
      logic aux_undervoltage_flag;
   } xreg3_stat_t;
endpackage

// File: hw/xreg3_sync.sv
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module xreg3_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   initial begin
      if (WIDTH < 1) begin
         $error("WIDTH must be at least one");
      end
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
